// >>> tbc_pkg.sv
/*
  Constants and state layout for the two-wire bus controller.
  Assumes a 10 MHz system clock and open-drain pads outside the block.
*/
package tbc_pkg;
  // ==========================================
  // timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int SCL_LOW_NS = 5000;  // scl low period
  localparam int SCL_HIGH_NS = 5000;
  localparam logic [15:0] LOW_CYC = 16'((SCL_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [15:0] HIGH_CYC = 16'((SCL_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  // ==========================================
  // field positions and codes
  localparam logic [1:0] MODE_BUS = 2'h2;  // interface mode field value
  localparam logic [2:0] BC_START = 3'h0;
  localparam logic [3:0] WORD_BITS = 4'h8;
  localparam int B_MST = 7;
  localparam int B_TRX = 6;
  localparam int B_BB = 5;
  localparam int B_PIN = 4;
  localparam int B_ACK = 4;
  localparam int B_SOFT_REINIT_BIT = 0;
  localparam int B_ALS = 0;
  // ==========================================
  // master sequencer states and block state layout
  typedef enum logic [6:0] {
    M_IDLE = 7'h01, M_START = 7'h02, M_LOW = 7'h04, M_HIGH = 7'h08,
    M_P1 = 7'h10, M_P2 = 7'h20, M_P3 = 7'h40
  } tbc_ms_t;
  typedef struct packed {
    logic scl_s1, scl_s2, sda_s1, sda_s2, scl_d, sda_d;
    logic controller_select, transmit_direction, bus_occupied, pin_n;
    logic arbitration_loss_flag, own_address_match_flag, general_call_flag, last_sampled_bit;
    logic [2:0] word_bit_count;
    logic ack;
    logic [1:0] interface_mode_field;
    logic soft_reinit_bit;
    logic [6:0] own_address_field;
    logic free_format_select;
    logic [7:0] shreg;
    logic [3:0] cnt;
    logic in_ack, first, sel, dir, stop_req;
    tbc_ms_t ms;
    logic [15:0] tmr;
    logic scl_oe, sda_oe, intr;
    logic [7:0] rdata, stat;
  } tbc_state_t;
  // synchronisers start at the idle-high bus level, so no false edge follows reset
  localparam tbc_state_t ST_RST = '{ms: M_IDLE, pin_n: 1'b1, stat: 8'h10, scl_s1: 1'b1, scl_s2: 1'b1,
    sda_s1: 1'b1, sda_s2: 1'b1, scl_d: 1'b1, sda_d: 1'b1, default: '0};
endpackage : tbc_pkg

// >>> tbc_ctrl.sv
/*
  Two-wire bus controller, master and slave, single clock domain.
  Assumes open-drain pads: a pin is pulled low while its enable is high.
*/
`timescale 1ns/1ns
`default_nettype none
module tbc_ctrl (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // first control register write
  input wire logic cr1_wr,
  input wire logic [7:0] cr1_wdata,
  // second control register write
  input wire logic cr2_wr,
  input wire logic [7:0] cr2_wdata,
  // own address register write
  input wire logic oar_wr,
  input wire logic [7:0] oar_wdata,
  // transfer buffer access
  input wire logic buf_wr,
  input wire logic [7:0] buf_wdata,
  input wire logic buf_rd,
  output logic [7:0] buf_rdata,
  // status and interrupt
  output logic [7:0] status,
  output logic transfer_interrupt,
  // bus pins
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe
);
  // ==========================================
  // state and decoded events
  tbc_pkg::tbc_state_t st_r, st_nxt;  // whole block state
  logic rise, fall, start_det, stop_det;  // bus edges
  logic start_req, stop_rq;  // software requests
  logic [3:0] nb;  // data bits per word
  logic arb_lost, ev, word_end, dd;

  // edges only ever look at second sync stage and its delay
  assign rise = st_r.scl_s2 && !st_r.scl_d;
  assign fall = !st_r.scl_s2 && st_r.scl_d;
  assign start_det = st_r.scl_s2 && st_r.scl_d && st_r.sda_d && !st_r.sda_s2;
  assign stop_det = st_r.scl_s2 && st_r.scl_d && !st_r.sda_d && st_r.sda_s2;
  assign nb = (st_r.word_bit_count == tbc_pkg::BC_START) ? tbc_pkg::WORD_BITS : {1'b0, st_r.word_bit_count};
  assign start_req = cr2_wr && cr2_wdata[tbc_pkg::B_MST] && cr2_wdata[tbc_pkg::B_TRX]
    && cr2_wdata[tbc_pkg::B_BB] && !st_r.bus_occupied && st_r.interface_mode_field == tbc_pkg::MODE_BUS;
  assign stop_rq = cr2_wr && cr2_wdata[tbc_pkg::B_MST] && cr2_wdata[tbc_pkg::B_TRX]
    && cr2_wdata[tbc_pkg::B_PIN] && !cr2_wdata[tbc_pkg::B_BB] && st_r.bus_occupied;
  // own one-level meets bus zero in a data slot
  assign arb_lost = rise && st_r.bus_occupied && st_r.controller_select && st_r.transmit_direction
    && !st_r.in_ack && st_r.cnt < nb && !st_r.sda_oe && !st_r.sda_s2;

  // ==========================================
  // next state
  always_comb begin
    st_nxt = st_r;
    ev = 1'b0;
    word_end = 1'b0;
    dd = 1'b0;
    // two-stage synchronisers
    st_nxt.scl_s1 = scl_i;
    st_nxt.scl_s2 = st_r.scl_s1;
    st_nxt.sda_s1 = sda_i;
    st_nxt.sda_s2 = st_r.sda_s1;
    st_nxt.scl_d = st_r.scl_s2;
    st_nxt.sda_d = st_r.sda_s2;
    st_nxt.intr = 1'b0;
    // software side first, so hardware events below win
    if (cr1_wr) begin
      st_nxt.word_bit_count = cr1_wdata[7:5];
      st_nxt.ack = cr1_wdata[tbc_pkg::B_ACK];
    end
    if (oar_wr) begin
      st_nxt.own_address_field = oar_wdata[7:1];
      st_nxt.free_format_select = oar_wdata[tbc_pkg::B_ALS];
    end
    if (buf_wr) begin
      st_nxt.shreg = buf_wdata;
    end
    if (buf_wr || buf_rd) begin
      st_nxt.pin_n = 1'b1;
      st_nxt.arbitration_loss_flag = 1'b0;
      st_nxt.own_address_match_flag = 1'b0;
    end
    if (cr2_wr) begin
      st_nxt.arbitration_loss_flag = 1'b0;
      st_nxt.interface_mode_field = cr2_wdata[3:2];
      st_nxt.soft_reinit_bit = cr2_wdata[tbc_pkg::B_SOFT_REINIT_BIT];
      if (cr2_wdata[tbc_pkg::B_PIN]) begin
        st_nxt.pin_n = 1'b1;
      end
      if (start_req) begin
        // start request, byte already in the buffer
        st_nxt.controller_select = 1'b1;
        st_nxt.transmit_direction = 1'b1;
        st_nxt.ms = tbc_pkg::M_START;
        st_nxt.tmr = 16'h0000;
      end else if (stop_rq) begin
        st_nxt.stop_req = 1'b1;
      end else if (!st_r.stop_req) begin
        // bits frozen while a stop is pending
        st_nxt.controller_select = cr2_wdata[tbc_pkg::B_MST];
        st_nxt.transmit_direction = cr2_wdata[tbc_pkg::B_TRX];
      end
    end
    // ==========================================
    // bus conditions and bit engine
    if (start_det) begin
      st_nxt.bus_occupied = 1'b1;
      st_nxt.general_call_flag = 1'b0;
      st_nxt.word_bit_count = tbc_pkg::BC_START;
      st_nxt.cnt = 4'h0;
      st_nxt.in_ack = 1'b0;
      st_nxt.first = 1'b1;
      st_nxt.sel = 1'b0;
    end else if (stop_det) begin
      st_nxt.bus_occupied = 1'b0;
      st_nxt.general_call_flag = 1'b0;
      st_nxt.controller_select = 1'b0;
      st_nxt.transmit_direction = 1'b0;
      st_nxt.stop_req = 1'b0;
      st_nxt.sel = 1'b0;
      st_nxt.first = 1'b0;
      st_nxt.ms = tbc_pkg::M_IDLE;
    end else if (rise && st_r.bus_occupied) begin
      st_nxt.last_sampled_bit = st_r.sda_s2;
      if (!st_r.in_ack && st_r.cnt < nb) begin
        st_nxt.shreg = {st_r.shreg[6:0], st_r.sda_s2};
        st_nxt.cnt = st_r.cnt + 4'h1;
      end
      if (arb_lost) begin
        st_nxt.arbitration_loss_flag = 1'b1;
        st_nxt.controller_select = 1'b0;
        st_nxt.transmit_direction = 1'b0;
        st_nxt.ms = tbc_pkg::M_IDLE;
      end
    end else if (fall && st_r.bus_occupied) begin
      if (!st_r.in_ack && st_r.cnt == nb) begin
        // address decode on the first word as slave
        if (st_r.first && !st_r.free_format_select && !st_r.controller_select) begin
          st_nxt.general_call_flag = (st_r.shreg == 8'h00);
          st_nxt.sel = (st_r.shreg == 8'h00) || (st_r.shreg[7:1] == st_r.own_address_field);
          st_nxt.own_address_match_flag = st_nxt.sel;
          st_nxt.dir = st_r.shreg[0] && st_r.shreg != 8'h00;
        end
        if (st_r.ack) begin
          st_nxt.in_ack = 1'b1;
        end else begin
          word_end = 1'b1;
        end
      end else if (st_r.in_ack) begin
        word_end = 1'b1;
      end
      if (word_end) begin
        st_nxt.cnt = 4'h0;
        st_nxt.in_ack = 1'b0;
        st_nxt.first = 1'b0;
        if (st_r.controller_select) begin
          ev = 1'b1;
          if (st_r.first && !st_r.last_sampled_bit) begin
            st_nxt.transmit_direction = !st_r.shreg[0];
          end
        end else if (st_nxt.sel || st_r.free_format_select || st_r.arbitration_loss_flag) begin
          ev = 1'b1;
          if (st_r.first && st_nxt.sel) begin
            st_nxt.transmit_direction = st_nxt.dir;
          end
          if (st_r.first && st_r.free_format_select) begin
            st_nxt.own_address_match_flag = 1'b1;
          end
        end
      end
      if (ev) begin
        st_nxt.intr = 1'b1;
        st_nxt.pin_n = 1'b0;
      end
    end
    // ==========================================
    // master clock sequencer
    case (st_r.ms)
      tbc_pkg::M_IDLE: begin
        // slave side: hold scl one low period after pending-n returns
        if (st_nxt.ms == tbc_pkg::M_START || st_nxt.pin_n) begin
          st_nxt.tmr = (st_nxt.ms == tbc_pkg::M_START || st_r.tmr == 16'h0000) ? 16'h0000 : st_r.tmr - 16'h0001;
        end else begin
          st_nxt.tmr = tbc_pkg::LOW_CYC;
        end
      end
      tbc_pkg::M_START, tbc_pkg::M_P1: begin
        // sda held low with scl high, or low before stop
        if (st_r.tmr >= tbc_pkg::LOW_CYC - 16'h0001) begin
          st_nxt.ms = (st_r.ms == tbc_pkg::M_START) ? tbc_pkg::M_LOW : tbc_pkg::M_P2;
          st_nxt.tmr = 16'h0000;
        end else begin
          st_nxt.tmr = st_r.tmr + 16'h0001;
        end
      end
      tbc_pkg::M_LOW: begin
        // low period restarts while service is pending
        if (!st_nxt.pin_n) begin
          st_nxt.tmr = 16'h0000;
        end else if (st_r.tmr >= tbc_pkg::LOW_CYC - 16'h0001) begin
          st_nxt.ms = st_r.stop_req ? tbc_pkg::M_P1 : tbc_pkg::M_HIGH;
          st_nxt.tmr = 16'h0000;
        end else begin
          st_nxt.tmr = st_r.tmr + 16'h0001;
        end
      end
      tbc_pkg::M_HIGH, tbc_pkg::M_P2: begin
        // high count waits for the wired line to rise
        if (!st_r.scl_s2) begin
          st_nxt.tmr = 16'h0000;
        end else if (st_r.tmr >= tbc_pkg::HIGH_CYC - 16'h0001) begin
          st_nxt.ms = (st_r.ms == tbc_pkg::M_HIGH) ? tbc_pkg::M_LOW : tbc_pkg::M_P3;
          st_nxt.tmr = 16'h0000;
        end else begin
          st_nxt.tmr = st_r.tmr + 16'h0001;
        end
      end
      tbc_pkg::M_P3: begin
        st_nxt.tmr = 16'h0000;  // wait for the stop to be seen
      end
      default: begin
        st_nxt.ms = tbc_pkg::M_IDLE;
      end
    endcase
    if (!st_nxt.controller_select && st_nxt.ms != tbc_pkg::M_P3 && st_nxt.ms != tbc_pkg::M_P2) begin
      st_nxt.ms = tbc_pkg::M_IDLE;  // lost or dropped mastership releases scl
      st_nxt.tmr = (st_r.ms == tbc_pkg::M_IDLE) ? st_nxt.tmr : 16'h0000;  // master count is no slave hold
    end
    // ==========================================
    // pin drive, data changes only while scl is seen low
    if (!st_r.in_ack && st_r.cnt < nb) begin
      dd = st_r.transmit_direction && !st_r.shreg[7] && (st_r.controller_select || st_r.sel);
    end else if (st_r.in_ack) begin
      dd = st_r.first ? (st_r.sel && !st_r.controller_select)
        : (!st_r.transmit_direction && (st_r.controller_select || st_r.sel));
    end
    if (st_nxt.ms == tbc_pkg::M_START || st_nxt.ms == tbc_pkg::M_P1 || st_nxt.ms == tbc_pkg::M_P2) begin
      st_nxt.sda_oe = 1'b1;
    end else if (st_nxt.ms == tbc_pkg::M_P3 || !st_r.bus_occupied || arb_lost) begin
      st_nxt.sda_oe = 1'b0;
    end else if (!st_r.scl_s2) begin
      st_nxt.sda_oe = dd;
    end
    st_nxt.scl_oe = st_nxt.ms == tbc_pkg::M_LOW || st_nxt.ms == tbc_pkg::M_P1
      || (!st_nxt.pin_n && st_nxt.bus_occupied)
      || (st_nxt.ms == tbc_pkg::M_IDLE && st_nxt.tmr != 16'h0000 && st_nxt.bus_occupied);
    if (st_nxt.interface_mode_field != tbc_pkg::MODE_BUS) begin
      st_nxt.scl_oe = 1'b0;  // port mode leaves the lines alone
      st_nxt.sda_oe = 1'b0;
    end
    st_nxt.rdata = st_nxt.shreg;
    st_nxt.stat = {st_nxt.controller_select, st_nxt.transmit_direction, st_nxt.bus_occupied,
      st_nxt.pin_n, st_nxt.arbitration_loss_flag, st_nxt.own_address_match_flag,
      st_nxt.general_call_flag, st_nxt.last_sampled_bit};
    // soft reinit: one cycle later everything but the synchronisers resets
    if (st_r.soft_reinit_bit) begin
      st_nxt = tbc_pkg::ST_RST;
      st_nxt.scl_s1 = st_r.scl_s1;
      st_nxt.scl_s2 = st_r.scl_s2;
      st_nxt.sda_s1 = st_r.sda_s1;
      st_nxt.sda_s2 = st_r.sda_s2;
      st_nxt.scl_d = st_r.scl_d;
      st_nxt.sda_d = st_r.sda_d;
      st_nxt.stat = 8'h10;
    end
  end

  // ==========================================
  // state register
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      st_r <= tbc_pkg::ST_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // outputs from the state register; scl_o and sda_o tied low
  assign buf_rdata = st_r.rdata;
  assign status = st_r.stat;
  assign transfer_interrupt = st_r.intr;
  assign scl_oe = st_r.scl_oe;
  assign sda_oe = st_r.sda_oe;
  assign scl_o = 1'b0;  // open drain: only ever pulls low
  assign sda_o = 1'b0;

  // ==========================================
  // checks
  a_start_req_sda: assert property (@(posedge clk_sys) disable iff (reset)
    start_req && !st_r.soft_reinit_bit |=> st_r.sda_oe || st_r.interface_mode_field != tbc_pkg::MODE_BUS)
    else $error("start request did not pull sda low");
  a_start_sets_bb: assert property (@(posedge clk_sys) disable iff (reset)
    start_det && !st_r.soft_reinit_bit |=> st_r.bus_occupied && st_r.word_bit_count == 3'h0)
    else $error("start not reflected in occupied flag or count");
  a_stop_clears_bb: assert property (@(posedge clk_sys) disable iff (reset)
    stop_det |=> !st_r.bus_occupied && !st_r.controller_select && !st_r.general_call_flag)
    else $error("stop did not free the bus");
  a_hold_scl_low: assert property (@(posedge clk_sys) disable iff (reset)
    !st_r.pin_n && st_r.bus_occupied && !st_r.soft_reinit_bit
    && st_r.interface_mode_field == tbc_pkg::MODE_BUS |=> st_r.scl_oe)
    else $error("scl released while service pending");
  a_intr_clears_pin: assert property (@(posedge clk_sys) disable iff (reset)
    $rose(st_r.intr) |-> !st_r.pin_n && !status[tbc_pkg::B_PIN] ##1 !st_r.intr)
    else $error("interrupt without pending-n cleared");
  a_zero_write_pin: assert property (@(posedge clk_sys) disable iff (reset)
    cr2_wr && !cr2_wdata[tbc_pkg::B_PIN] && st_r.pin_n && !ev && !st_r.soft_reinit_bit |=> st_r.pin_n)
    else $error("writing zero cleared pending-n");
  a_buf_sets_pin: assert property (@(posedge clk_sys) disable iff (reset)
    (buf_wr || buf_rd) && !ev && !st_r.soft_reinit_bit |=> st_r.pin_n && !st_r.own_address_match_flag)
    else $error("buffer access did not set pending-n");
  a_al_to_slave: assert property (@(posedge clk_sys) disable iff (reset)
    arb_lost && !st_r.soft_reinit_bit |=> st_r.arbitration_loss_flag && !st_r.controller_select
    && !st_r.transmit_direction && !st_r.sda_oe)
    else $error("arbitration loss did not drop to slave");
  a_al_clear: assert property (@(posedge clk_sys) disable iff (reset)
    (buf_wr || buf_rd || cr2_wr) && !arb_lost |=> !st_r.arbitration_loss_flag)
    else $error("loss flag survived clearing access");
  a_lrb_sample: assert property (@(posedge clk_sys) disable iff (reset)
    rise && st_r.bus_occupied && !st_r.soft_reinit_bit |=> st_r.last_sampled_bit == $past(st_r.sda_s2))
    else $error("last sampled bit wrong");
  a_reinit_self: assert property (@(posedge clk_sys) disable iff (reset)
    st_r.soft_reinit_bit |=> !st_r.soft_reinit_bit && st_r.pin_n && !st_r.controller_select)
    else $error("soft reinit did not reset and self-clear");
  a_release_low: assert property (@(posedge clk_sys) disable iff (reset)
    $rose(st_r.pin_n) && st_r.ms == tbc_pkg::M_LOW |-> st_r.scl_oe [*8])
    else $error("scl released before low period");
endmodule : tbc_ctrl
`default_nettype wire

// >>> tbc_bus_slave.sv
/*
  behavioural slave device for the two-wire bench.
  assumes pulled-up bus lines: the model only ever pulls sda low.
*/
`timescale 1ns/1ns
`default_nettype none
module tbc_bus_slave #(
  parameter logic [6:0] ADDR = 7'h2a  // address this model answers to
) (
  // wired bus levels
  input wire logic scl,
  input wire logic sda,
  // pull-down request for sda
  output logic sda_low
);
  // ==========================================
  // frame state
  logic [7:0] sh;  // bits shifted in
  int n;  // bits seen in this word
  logic live;  // inside a frame
  logic first;  // on the address byte
  logic hit;  // addressed in this frame
  initial begin
    sda_low = 1'b0;
    hit = 1'b0;
    n = 0;
    live = 1'b0;
    first = 1'b0;
    sh = 8'h00;
  end
  // start: sda falls while scl high
  always @(negedge sda) begin
    if (scl) begin
      live = 1'b1;
      first = 1'b1;
      n = 0;
    end
  end
  // stop: sda rises while scl high, frees the line
  always @(posedge sda) begin
    if (scl) begin
      live = 1'b0;
      sda_low = 1'b0;
    end
  end
  // data is taken on the rising clock
  always @(posedge scl) begin
    if (live && n < 8) begin
      sh = {sh[6:0], sda};
      n = n + 1;
    end
  end
  // ack its own address, and data words ending in zero; a word ending in one is refused
  always @(negedge scl) begin
    if (live && n == 8) begin
      if (first) begin
        hit = (sh[7:1] == ADDR);
      end
      sda_low = hit && (first || !sh[0]);
      n = 9;
    end else if (live && n == 9) begin
      sda_low = 1'b0;
      first = 1'b0;
      n = 0;
    end
  end
endmodule : tbc_bus_slave
`default_nettype wire

// >>> testbench.sv
/*
  self-checking bench for the two-wire bus controller.
  assumes the slave model on the wired bus; the bench is a second master too.
*/
`timescale 1ns/1ns
`default_nettype none
module testbench;
  // ==========================================
  // design ports and wired bus
  logic clk_sys, reset, cr1_wr, cr2_wr, oar_wr, buf_wr, buf_rd;
  logic [7:0] cr1_wdata, cr2_wdata, oar_wdata, buf_wdata, buf_rdata, status;
  logic transfer_interrupt, scl_oe, sda_oe, tb_scl_low, tb_sda_low, slv_sda_low, int_seen;
  wire logic scl_bus;
  wire logic sda_bus;
  assign scl_bus = !(scl_oe || tb_scl_low);  // open drain, pulled up
  assign sda_bus = !(sda_oe || tb_sda_low || slv_sda_low);
  int miscompares, checks, rises;
  localparam int CR1 = 0;  // strobe select codes
  localparam int CR2 = 1;
  localparam int OAR = 2;
  localparam int BUFW = 3;
  localparam int BUFR = 4;
  tbc_ctrl dut (.clk_sys(clk_sys), .reset(reset), .cr1_wr(cr1_wr), .cr1_wdata(cr1_wdata),
    .cr2_wr(cr2_wr), .cr2_wdata(cr2_wdata), .oar_wr(oar_wr), .oar_wdata(oar_wdata),
    .buf_wr(buf_wr), .buf_wdata(buf_wdata), .buf_rd(buf_rd), .buf_rdata(buf_rdata),
    .status(status), .transfer_interrupt(transfer_interrupt), .scl_i(scl_bus), .scl_o(),
    .scl_oe(scl_oe), .sda_i(sda_bus), .sda_o(), .sda_oe(sda_oe));
  tbc_bus_slave #(.ADDR(7'h2a)) slave (.scl(scl_bus), .sda(sda_bus), .sda_low(slv_sda_low));
  // ==========================================
  // clock, pulse counters
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  always @(posedge scl_bus) rises = rises + 1;
  // the interrupt stands one cycle, so the falling edge always sees it
  always @(negedge clk_sys) if (transfer_interrupt === 1'b1) int_seen = 1'b1;
  // ==========================================
  // shared tasks
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks = checks + 1;
    if (got !== exp) begin
      miscompares = miscompares + 1;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // one-cycle strobe, entered at a falling edge
  task automatic pulse(input int k, input logic [7:0] d);
    {cr1_wdata, cr2_wdata, oar_wdata, buf_wdata} = {4{d}};
    {cr1_wr, cr2_wr, oar_wr, buf_wr, buf_rd} = 5'h10 >> k;
    @(negedge clk_sys);
    {cr1_wr, cr2_wr, oar_wr, buf_wr, buf_rd} = 5'h00;
  endtask : pulse
  task automatic wait_stat(input int b, input logic v, input int limit);
    for (int i = 0; i < limit && status[b] !== v; i++) @(negedge clk_sys);
    chk(8'(status[b]), 8'(v));
  endtask : wait_stat
  task automatic wait_int(input int limit);
    for (int i = 0; i < limit && !int_seen; i++) @(negedge clk_sys);
    chk(8'(int_seen), 8'h01);
    @(negedge clk_sys);
  endtask : wait_int
  task automatic final_report;
    $display("checks=%0d miscompares=%0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : final_report
  // ==========================================
  // scenarios
  task automatic s_init;
    chk(status, 8'h10);
    chk(8'({scl_oe, sda_oe}), 8'h00);
    pulse(CR1, 8'h10);
    pulse(OAR, 8'h66);
    pulse(CR2, 8'h18);
    chk(status, 8'h10);
  endtask : s_init
  // address, two data words, stop
  task automatic s_master;
    int i;
    pulse(BUFW, 8'h54);
    rises = 0;
    int_seen = 1'b0;
    pulse(CR2, 8'hf8);
    chk(8'({status[7:6], sda_oe, scl_oe}), 8'h0e);
    wait_stat(5, 1'b1, 20);
    wait_int(3000);
    chk(8'(rises), 8'h09);
    chk(status, 8'he0);
    repeat (100) @(negedge clk_sys);
    chk(8'(scl_oe), 8'h01);
    pulse(CR2, 8'he8);
    chk(8'(status[4]), 8'h00);
    rises = 0;
    int_seen = 1'b0;
    pulse(BUFW, 8'h5a);
    chk(8'(status[4]), 8'h01);
    for (i = 0; i < 200 && scl_oe === 1'b1; i++) @(negedge clk_sys);
    chk(8'(i >= tbc_pkg::LOW_CYC - 3 && i <= tbc_pkg::LOW_CYC + 2), 8'h01);
    wait_int(3000);
    chk(8'(rises), 8'h09);
    chk(status, 8'he0);
    pulse(CR1, 8'h60);
    rises = 0;
    int_seen = 1'b0;
    pulse(BUFW, 8'ha5);
    wait_int(3000);
    chk(8'(rises), 8'h03);
    chk(8'(status[0]), 8'h01);
    pulse(CR2, 8'hd8);
    chk(8'(status[7:6]), 8'h03);
    wait_stat(5, 1'b0, 600);
    chk(8'(status[7:5]), 8'h00);
    pulse(CR1, 8'h10);
  endtask : s_master
  // bench pulls sda low under the first address bit
  task automatic s_arb;
    chk(8'(status[5]), 8'h00);
    pulse(BUFW, 8'ha0);
    pulse(CR2, 8'hf8);
    wait_stat(5, 1'b1, 20);
    tb_sda_low = 1'b1;
    wait_stat(3, 1'b1, 300);
    chk(8'(status[7:6]), 8'h00);
    repeat (3) @(negedge clk_sys);
    chk(8'({scl_oe, sda_oe}), 8'h00);
    tb_sda_low = 1'b0;
    wait_stat(5, 1'b0, 20);
    pulse(BUFR, 8'h00);
    chk(8'(status[3]), 8'h00);
  endtask : s_arb
  // bench masters a general call on an 800 ns clock
  task automatic s_gcall;
    int_seen = 1'b0;
    #37 tb_sda_low = 1'b1;
    #400;
    for (int b = 0; b < 8; b++) begin
      tb_scl_low = 1'b1;
      #400 tb_scl_low = 1'b0;
      #400;
    end
    tb_scl_low = 1'b1;
    #200 tb_sda_low = 1'b0;
    #200 chk(8'(sda_oe), 8'h01);
    tb_scl_low = 1'b0;
    #400 tb_scl_low = 1'b1;
    #400 chk(8'(int_seen), 8'h01);
    chk(status, 8'h26);
    @(negedge clk_sys);
    pulse(BUFR, 8'h00);
    chk(status, 8'h32);
    pulse(CR2, 8'h01);
    repeat (2) @(negedge clk_sys);
    chk(status, 8'h10);
    chk(8'({scl_oe, sda_oe}), 8'h00);
    tb_sda_low = 1'b1;
    tb_scl_low = 1'b0;
    #400 tb_sda_low = 1'b0;
    #400;
  endtask : s_gcall
  // ==========================================
  // main sequence and watchdog
  initial begin
    reset = 1'b1;
    {cr1_wr, cr2_wr, oar_wr, buf_wr, buf_rd} = 5'h00;
    {cr1_wdata, cr2_wdata, oar_wdata, buf_wdata} = 32'h0;
    {tb_scl_low, tb_sda_low, int_seen} = 3'h0;
    miscompares = 0;
    checks = 0;
    rises = 0;
    repeat (20) @(negedge clk_sys);
    reset = 1'b0;
    @(negedge clk_sys);
    s_init;
    s_master;
    s_arb;
    s_gcall;
    final_report;
  end
  initial begin
    #(100 * 40000);
    miscompares = miscompares + 1;
    final_report;
  end
endmodule : testbench
`default_nettype wire
